// *** usb_interrupt_register_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

module usb_interrupt_register_bank (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic [11:0] dataAddr,
	input  wire logic        dataWr,
	input  wire logic        dataRd,
	input  wire logic [7:0]  dataWdata,
	output logic      [7:0]  dataRdata,
	output logic             regHit,
	input  wire logic [6:0]  intEvent,
	input  wire logic [7:0]  errEvent,
	input  wire logic [7:0]  statIn,
	input  wire logic [10:0] frameIn,
	input  wire logic [4:0]  ctrlStatus,
	output logic      [7:0]  usbControl,
	output logic      [7:0]  usbConfig,
	output logic      [6:0]  devAddress,
	output logic      [4:0]  epControl [16],
	output logic             usbIrq
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [7:0]      ctrl;
		logic [7:0]      cfg;
		logic [7:0]      addr;
		logic [7:0]      iflag;
		logic [7:0]      ien;
		logic [7:0]      eflag;
		logic [7:0]      een;
		logic [15:0][7:0] ep;
		logic [7:0]      rdata;
		logic            irq;
	} bank_s;

	bank_s state_ff;
	bank_s nxt_state;
	logic  bankSel;
	logic  epSel;
	logic [3:0] epIdx;
	logic [7:0] epOfs;
	logic [7:0] ofs;
	logic [7:0] rdMux;
	logic       errAny;
	logic [7:0] iflagEff;

	// ==========================================================
	// Decode
	// ==========================================================
	assign bankSel = (dataAddr[11:8] == usb_irq_pkg::SFR_BANK);
	assign ofs     = dataAddr[7:0];
	assign epOfs   = ofs - usb_irq_pkg::OFS_EP0;
	assign epSel   = bankSel && (epOfs < 8'(usb_irq_pkg::NUM_EP));
	assign epIdx   = epOfs[3:0];

	always_comb begin
		rdMux  = usb_irq_pkg::RST_VALUE;
		regHit = 1'b1;
		if (epSel) begin
			rdMux = state_ff.ep[epIdx] & usb_irq_pkg::MASK_EP;
		end else if (!bankSel) begin
			regHit = 1'b0;
		end else begin
			unique case (ofs)
				usb_irq_pkg::OFS_CTRL:  rdMux = state_ff.ctrl;
				usb_irq_pkg::OFS_CFG:   rdMux = state_ff.cfg;
				usb_irq_pkg::OFS_STAT:
					rdMux = statIn & usb_irq_pkg::MASK_STAT;
				usb_irq_pkg::OFS_ADDR:  rdMux = state_ff.addr;
				usb_irq_pkg::OFS_FRML:  rdMux = frameIn[7:0];
				usb_irq_pkg::OFS_FRMH:
					rdMux = {5'h00, frameIn[10:8]};
				usb_irq_pkg::OFS_IFLAG: rdMux = state_ff.iflag;
				usb_irq_pkg::OFS_IEN:   rdMux = state_ff.ien;
				usb_irq_pkg::OFS_EFLAG: rdMux = state_ff.eflag;
				usb_irq_pkg::OFS_EEN:   rdMux = state_ff.een;
				default:                regHit = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Next state
	// ==========================================================
	assign errAny = |(state_ff.eflag & state_ff.een);

	always_comb begin
		nxt_state = state_ff;
		iflagEff  = state_ff.iflag;
		if (dataRd) begin
			nxt_state.rdata = rdMux;
		end
		if (dataWr && epSel) begin
			nxt_state.ep[epIdx] = dataWdata & usb_irq_pkg::MASK_EP;
		end else if (dataWr && bankSel) begin
			unique case (ofs)
				usb_irq_pkg::OFS_CTRL: nxt_state.ctrl =
					(dataWdata & usb_irq_pkg::MASK_CTRL) |
					{2'b00, ctrlStatus[4], 5'h00};
				usb_irq_pkg::OFS_CFG:
					nxt_state.cfg = dataWdata & usb_irq_pkg::MASK_CFG;
				usb_irq_pkg::OFS_ADDR:
					nxt_state.addr = dataWdata & usb_irq_pkg::MASK_ADDR;
				usb_irq_pkg::OFS_IFLAG:
					iflagEff = state_ff.iflag & dataWdata;
				usb_irq_pkg::OFS_IEN:
					nxt_state.ien = dataWdata & usb_irq_pkg::MASK_INT;
				usb_irq_pkg::OFS_EFLAG: nxt_state.eflag =
					state_ff.eflag & dataWdata;
				usb_irq_pkg::OFS_EEN:
					nxt_state.een = dataWdata & usb_irq_pkg::MASK_ERR;
				default: ;
			endcase
		end
		// Hardware set wins over software clear
		nxt_state.eflag = nxt_state.eflag |
			(errEvent & usb_irq_pkg::MASK_ERR);
		nxt_state.iflag = (iflagEff | {1'b0, intEvent}) &
			usb_irq_pkg::MASK_INT;
		nxt_state.iflag[usb_irq_pkg::BIT_USB_ERROR] =
			nxt_state.iflag[usb_irq_pkg::BIT_USB_ERROR] | errAny;
		// Per-source gates
		// and
		nxt_state.irq = |(state_ff.iflag & state_ff.ien);
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= '0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	// Engine side runs from its own 48 MHz source; only levels meet here
	assign dataRdata  = state_ff.rdata;
	assign usbControl = state_ff.ctrl;
	assign usbConfig  = state_ff.cfg;
	assign devAddress = state_ff.addr[6:0];
	assign usbIrq     = state_ff.irq;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : gEp
			assign epControl[g] = state_ff.ep[g][4:0];
		end
	endgenerate

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic       wrIen;
	logic       wrIflag;
	logic [7:0] gated;

	assign wrIen   = clkEn && dataWr && bankSel &&
		ofs == usb_irq_pkg::OFS_IEN;
	assign wrIflag = clkEn && dataWr && bankSel &&
		ofs == usb_irq_pkg::OFS_IFLAG;
	assign gated   = state_ff.iflag & state_ff.ien;

	// ==========================================================
	// Propagation per source
	// ==========================================================
	AST_IDLE_GATE: assert property (
		clkEn && state_ff.iflag[4] && !state_ff.ien[4] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("idle irq while disabled");
	AST_IDLE_PROP: assert property (
		clkEn && state_ff.ien[4] && state_ff.iflag[4] |=> usbIrq)
		else $error("idle irq lost");
	AST_TRN_PROP: assert property (
		clkEn && state_ff.ien[3] && state_ff.iflag[3] |=> usbIrq)
		else $error("transaction irq lost");
	AST_TRN_MASK: assert property (
		clkEn && state_ff.iflag[3] && !state_ff.ien[3] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("transaction irq while disabled");
	AST_ACT_PROP: assert property (
		clkEn && state_ff.ien[2] && state_ff.iflag[2] |=> usbIrq)
		else $error("activity irq lost");
	AST_ACT_MASK: assert property (
		clkEn && state_ff.iflag[2] && !state_ff.ien[2] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("activity irq while disabled");
	AST_ERR_PROP: assert property (
		clkEn && state_ff.ien[1] && state_ff.iflag[1] |=> usbIrq)
		else $error("error irq lost");
	AST_ERR_MASK: assert property (
		clkEn && state_ff.iflag[1] && !state_ff.ien[1] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("error irq while disabled");
	AST_RST_PROP: assert property (
		clkEn && state_ff.ien[0] && state_ff.iflag[0] |=> usbIrq)
		else $error("bus reset irq lost");
	AST_RST_MASK: assert property (
		clkEn && state_ff.iflag[0] && !state_ff.ien[0] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("bus reset irq while disabled");
	AST_SOF_PROP: assert property (
		clkEn && state_ff.ien[6] && state_ff.iflag[6] |=> usbIrq)
		else $error("frame irq lost");
	AST_SOF_MASK: assert property (
		clkEn && state_ff.iflag[6] && !state_ff.ien[6] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("frame irq while disabled");
	AST_STALL_PROP: assert property (
		clkEn && state_ff.ien[5] && state_ff.iflag[5] |=> usbIrq)
		else $error("stall irq lost");
	AST_STALL_MASK: assert property (
		clkEn && state_ff.iflag[5] && !state_ff.ien[5] &&
		gated == 8'h00 |=> !usbIrq)
		else $error("stall irq while disabled");
	AST_IRQ_CAUSE: assert property (
		clkEn ##1 usbIrq |-> $past(|gated))
		else $error("irq without cause");
	AST_IRQ_QUIET: assert property (
		clkEn && gated == 8'h00 |=> !usbIrq)
		else $error("irq with no enabled flag");

	// ==========================================================
	// Flags and polling
	// ==========================================================
	AST_FLAG_POLL: assert property (
		clkEn && intEvent[4] |=> state_ff.iflag[4])
		else $error("flag not set while masked");
	AST_POLL_RST: assert property (
		clkEn && intEvent[0] |=> state_ff.iflag[0])
		else $error("bus reset flag not set");
	AST_POLL_ERR: assert property (
		clkEn && intEvent[1] |=> state_ff.iflag[1])
		else $error("error flag not set");
	AST_POLL_ACT: assert property (
		clkEn && intEvent[2] |=> state_ff.iflag[2])
		else $error("activity flag not set");
	AST_POLL_TRN: assert property (
		clkEn && intEvent[3] |=> state_ff.iflag[3])
		else $error("transaction flag not set");
	AST_POLL_STALL: assert property (
		clkEn && intEvent[5] |=> state_ff.iflag[5])
		else $error("stall flag not set");
	AST_POLL_SOF: assert property (
		clkEn && intEvent[6] |=> state_ff.iflag[6])
		else $error("frame flag not set");
	AST_SET_WINS: assert property (
		wrIflag && intEvent[3] |=> state_ff.iflag[3])
		else $error("clear beat a set");
	AST_FLAG_CLEAR: assert property (
		wrIflag && !dataWdata[2] && !intEvent[2]
		|=> !state_ff.iflag[2])
		else $error("flag not cleared");
	AST_EN_KEEPS_FLAG: assert property (
		wrIen && intEvent == 7'h00 && !errAny
		|=> $stable(state_ff.iflag))
		else $error("enable write moved a flag");
	AST_ERR_FLAG_SET: assert property (
		clkEn && errEvent[7] |=> state_ff.eflag[7])
		else $error("error source flag not set");
	AST_ERR_TO_FLAG: assert property (
		clkEn && errAny |=> state_ff.iflag[1])
		else $error("enabled error did not reach flag");

	// ==========================================================
	// Decode and read-back
	// ==========================================================
	AST_UNIMP_ZERO: assert property (
		clkEn && dataRd && bankSel && ofs == usb_irq_pkg::OFS_IEN
		|=> !dataRdata[7])
		else $error("unimplemented bit read as one");
	AST_IFLAG_B7: assert property (
		clkEn |=> !state_ff.iflag[7])
		else $error("flag bit 7 set");
	AST_IEN_B7: assert property (
		clkEn |=> !state_ff.ien[7])
		else $error("enable bit 7 set");
	AST_EFLAG_GAP: assert property (
		clkEn |=> state_ff.eflag[6:5] == 2'b00)
		else $error("error flag gap set");
	AST_ADDR_B7: assert property (
		clkEn |=> !state_ff.addr[7])
		else $error("address bit 7 set");
	AST_FRMH_READ: assert property (
		clkEn && dataRd && bankSel && ofs == usb_irq_pkg::OFS_FRMH
		|=> dataRdata[7:3] == 5'h00)
		else $error("frame high bits read as one");
	AST_STAT_READ: assert property (
		clkEn && dataRd && bankSel && ofs == usb_irq_pkg::OFS_STAT
		|=> !dataRdata[7] && !dataRdata[0])
		else $error("status spare bits read as one");
	AST_EP_READ: assert property (
		clkEn && dataRd && epSel |=> dataRdata[7:5] == 3'h0)
		else $error("endpoint spare bits read as one");
	AST_OUT_BANK_READ: assert property (
		clkEn && dataRd && !bankSel |=> dataRdata == 8'h00)
		else $error("read outside bank not zero");
	AST_OUT_BANK_HIT: assert property (
		!bankSel |-> !regHit)
		else $error("hit outside bank");
	AST_OUT_BANK_WRITE: assert property (
		clkEn && dataWr && !bankSel
		|=> $stable(state_ff.ien) && $stable(state_ff.ep))
		else $error("write outside bank landed");
	AST_BD_BANK_HIT: assert property (
		dataAddr[11:8] == usb_irq_pkg::BD_BANK
		|-> !regHit)
		else $error("descriptor bank decoded here");

	// ==========================================================
	// Reset, clock enable and writes
	// ==========================================================
	AST_RESET_ZERO: assert property (@(posedge sys_clk)
		disable iff (1'b0) rst |-> state_ff.ien == 8'h00 && !usbIrq)
		else $error("enables not zero in reset");
	AST_FREEZE: assert property (
		!clkEn |=> $stable(state_ff))
		else $error("state moved with clock enable low");
	AST_IEN_WRITE: assert property (
		wrIen |=> state_ff.ien == ($past(dataWdata) & 8'h7f))
		else $error("enable write did not land");
	AST_RDATA_HOLD: assert property (
		clkEn && !dataRd |=> $stable(dataRdata))
		else $error("read data moved without a read");

endmodule : usb_interrupt_register_bank

`default_nettype wire

// *** usb_interrupt_register_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module usb_interrupt_register_bank_test;

	// ==========================================================
	// Signals
	// ==========================================================
	logic        sys_clk;
	logic        rst;
	logic        clkEn;
	logic [11:0] dataAddr;
	logic        dataWr;
	logic        dataRd;
	logic [7:0]  dataWdata;
	logic [7:0]  dataRdata;
	logic        regHit;
	logic [6:0]  intEvent;
	logic [7:0]  errEvent;
	logic [7:0]  statIn;
	logic [10:0] frameIn;
	logic [4:0]  ctrlStatus;
	logic [7:0]  usbControl;
	logic [7:0]  usbConfig;
	logic [6:0]  devAddress;
	logic [4:0]  epCtl [16];
	logic        usbIrq;
	logic [7:0]  d;
	logic        h;
	int          errors;
	int          nTests;

	usb_interrupt_register_bank u_dut (
		.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .dataAddr(dataAddr),
		.dataWr(dataWr), .dataRd(dataRd), .dataWdata(dataWdata),
		.dataRdata(dataRdata), .regHit(regHit), .intEvent(intEvent),
		.errEvent(errEvent), .statIn(statIn), .frameIn(frameIn),
		.ctrlStatus(ctrlStatus), .usbControl(usbControl),
		.usbConfig(usbConfig), .devAddress(devAddress),
		.epControl(epCtl), .usbIrq(usbIrq)
	);

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic conclude();
		if (errors == 0 && nTests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nTests++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		#1 dataAddr = a;
		dataWdata = v;
		dataWr = 1'b1;
		@(posedge sys_clk);
		#1 dataWr = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [7:0] v,
		output logic hit);
		@(posedge sys_clk);
		#1 dataAddr = a;
		dataRd = 1'b1;
		#1 hit = regHit;
		@(posedge sys_clk);
		#1 dataRd = 1'b0;
		v = dataRdata;
	endtask : rd

	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : settle

	// Flag sets with enable off, then enable gates the request
	task automatic bitCase(input int n);
		logic [7:0] m;
		m = 8'h01 << n;
		wr(12'hf36, 8'h00);
		wr(12'hf62, 8'h00);
		@(posedge sys_clk);
		#1 intEvent = m[6:0];
		@(posedge sys_clk);
		#1 intEvent = 7'h00;
		settle();
		chk({7'h00, usbIrq}, 8'h00);
		rd(12'hf62, d, h);
		chk(d, m);
		wr(12'hf36, m);
		settle();
		chk({7'h00, usbIrq}, 8'h01);
		wr(12'hf36, ~m & 8'h7f);
		settle();
		chk({7'h00, usbIrq}, 8'h00);
	endtask : bitCase

	// ==========================================================
	// Clock, watchdog, tests
	// ==========================================================
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial begin
		#200000;
		errors++;
		conclude();
	end

	initial begin
		errors = 0;
		nTests = 0;
		rst = 1'b1;
		clkEn = 1'b1;
		dataAddr = 12'h000;
		dataWr = 1'b0;
		dataRd = 1'b0;
		dataWdata = 8'h00;
		intEvent = 7'h00;
		errEvent = 8'h00;
		statIn = 8'hff;
		frameIn = 11'h5a5;
		ctrlStatus = 5'h00;
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk({7'h00, usbIrq}, 8'h00);
		rd(12'hf36, d, h);
		chk(d, 8'h00);
		chk({7'h00, h}, 8'h01);
		wr(12'hf36, 8'hff);
		rd(12'hf36, d, h);
		chk(d, 8'h7f);
		rd(12'hf64, d, h);
		chk(d, 8'h7e);
		rd(12'hf66, d, h);
		chk(d, 8'ha5);
		rd(12'hf67, d, h);
		chk(d, 8'h05);
		rd(12'he36, d, h);
		chk(d, 8'h00);
		chk({7'h00, h}, 8'h00);
		rd(12'h436, d, h);
		chk({7'h00, h}, 8'h00);
		wr(12'hf39, 8'hff);
		chk(usbConfig, 8'hdf);
		wr(12'hf38, 8'hff);
		chk({1'b0, devAddress}, 8'h7f);
		ctrlStatus = 5'h10;
		wr(12'hf65, 8'h00);
		chk(usbControl, 8'h20);
		wr(12'hf35, 8'hff);
		chk({3'h0, epCtl[15]}, 8'h1f);
		rd(12'hf35, d, h);
		chk(d, 8'h1f);
		clkEn = 1'b0;
		wr(12'hf38, 8'h11);
		clkEn = 1'b1;
		chk({1'b0, devAddress}, 8'h7f);
		wr(12'hf37, 8'h00);
		@(posedge sys_clk);
		#1 errEvent = 8'hff;
		@(posedge sys_clk);
		#1 errEvent = 8'h00;
		rd(12'hf63, d, h);
		chk(d, 8'h9f);
		rd(12'hf62, d, h);
		chk(d, 8'h00);
		wr(12'hf37, 8'h01);
		settle();
		rd(12'hf62, d, h);
		chk(d, 8'h02);
		wr(12'hf63, 8'h00);
		wr(12'hf37, 8'h00);
		for (int n = 0; n < 7; n++) begin
			bitCase(n);
		end
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk(usbConfig, 8'h00);
		rd(12'hf36, d, h);
		chk(d, 8'h00);
		conclude();
	end

endmodule : usb_interrupt_register_bank_test

`default_nettype wire

// *** usb_irq_pkg.sv ***
package usb_irq_pkg;

	// ==========================================================
	// Data memory map
	// ==========================================================
	localparam logic [11:0] REG_BANK_BASE  = 12'hf00;
	localparam logic [11:0] BD_BANK_BASE   = 12'h400;
	localparam logic [3:0]  SFR_BANK       = 4'hf;
	localparam logic [3:0]  BD_BANK        = 4'h4;
	localparam logic [7:0]  OFS_CTRL       = 8'h65;
	localparam logic [7:0]  OFS_CFG        = 8'h39;
	localparam logic [7:0]  OFS_STAT       = 8'h64;
	localparam logic [7:0]  OFS_ADDR       = 8'h38;
	localparam logic [7:0]  OFS_FRML       = 8'h66;
	localparam logic [7:0]  OFS_FRMH       = 8'h67;
	localparam logic [7:0]  OFS_IFLAG      = 8'h62;
	localparam logic [7:0]  OFS_IEN        = 8'h36;
	localparam logic [7:0]  OFS_EFLAG      = 8'h63;
	localparam logic [7:0]  OFS_EEN        = 8'h37;
	localparam logic [7:0]  OFS_EP0        = 8'h26;
	localparam int          NUM_EP         = 16;

	// ==========================================================
	// Implemented bit masks
	// ==========================================================
	localparam logic [7:0] MASK_CTRL  = 8'h7e;
	localparam logic [7:0] MASK_CFG   = 8'hdf;
	localparam logic [7:0] MASK_STAT  = 8'h7e;
	localparam logic [7:0] MASK_ADDR  = 8'h7f;
	localparam logic [7:0] MASK_FRMH  = 8'h07;
	localparam logic [7:0] MASK_INT   = 8'h7f;
	localparam logic [7:0] MASK_ERR   = 8'h9f;
	localparam logic [7:0] MASK_EP    = 8'h1f;

	// ==========================================================
	// Interrupt enable field positions
	// ==========================================================
	localparam int BIT_BUS_RESET  = 0;
	localparam int BIT_USB_ERROR  = 1;
	localparam int BIT_ACTIVITY   = 2;
	localparam int BIT_TRN_DONE   = 3;
	localparam int BIT_IDLE       = 4;
	localparam int BIT_STALL      = 5;
	localparam int BIT_SOF        = 6;

	// ==========================================================
	// Reset values and clocks
	// ==========================================================
	localparam logic [7:0] RST_VALUE     = 8'h00;
	localparam int         USB_CLK_MHZ   = 48;

endpackage : usb_irq_pkg
